// ---- rtl/prs_cfg.svh ----
// prs_cfg.svh: timing constants for the reset and power-up sequencer pair.
// assumes a 200 MHz clock; times in ns, cycle counts derived here.
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH
`define PRS_CLK_MHZ 200
`define PRS_INIT_NS 150000
`define PRS_RP_NS 200
`define PRS_RH_NS 200
`define PRS_RPH_NS 400
// longest time rounds down, least times round up
`define PRS_INIT_CYC ((`PRS_INIT_NS * `PRS_CLK_MHZ) / 1000)
`define PRS_RP_CYC ((`PRS_RP_NS * `PRS_CLK_MHZ + 999) / 1000)
`define PRS_RH_CYC ((`PRS_RH_NS * `PRS_CLK_MHZ + 999) / 1000)
`define PRS_RPH_CYC ((`PRS_RPH_NS * `PRS_CLK_MHZ + 999) / 1000)
// cycles from a pin edge to the device state register:
// three sync flops, the agreement flop and the state flop
`define PRS_PIN_LAT_CYC 5
`define PRS_ROW_RST 16'h0000
`define PRS_CFG_RST 16'h8f1f
`endif

// ---- rtl/prs_pkg.sv ----
// prs_pkg.sv: shared types of the sequencer pair.
// assumes nothing beyond the compiler.
`default_nettype none
package prs_pkg;
  typedef enum logic [2:0] {
    PRS_OFF = 3'b000,
    PRS_INIT = 3'b001,
    PRS_READY = 3'b011,
    PRS_SLEEP = 3'b010,
    PRS_HOLD = 3'b110
  } prs_dev_e;
  typedef enum logic [2:0] {
    PRH_RESET = 3'b000,
    PRH_GAP = 3'b001,
    PRH_WAIT = 3'b011,
    PRH_IDLE = 3'b010,
    PRH_BUSY = 3'b110
  } prs_host_e;
endpackage
`default_nettype wire

// ---- rtl/prs_link_if.sv ----
// prs_link_if.sv: link between host and memory device (restore and select).
// assumes both ends run on the same clk.
`timescale 1ns/100ps
`default_nettype none
interface prs_link_if;
  logic restoreN;
  logic selectN;
  modport host (output restoreN, output selectN);
  modport dev (input restoreN, input selectN);
endinterface
`default_nettype wire

// ---- rtl/prs_device.sv ----
// prs_device.sv: device end; power-up init, hardware restore, refresh control.
// assumes restoreN and selectN arrive as pins from the host.
// pins are taken through a three-flop bank, so every reaction to the host
// lags its pin by a few cycles; all outputs come from flops.
`timescale 1ns/100ps
`default_nettype none
`include "prs_cfg.svh"
module prs_device
  import prs_pkg::*;
#(
  parameter int INIT_CYC = `PRS_INIT_CYC,
  parameter int ROW_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // supply sensor
  input wire logic supplyOk,
  // link
  prs_link_if.dev link,
  // user side
  input wire logic sleepReq,
  input wire logic [15:0] cfgWrData,
  input wire logic cfgWrEn,
  output logic ready,
  output logic refreshOn,
  output logic [ROW_W-1:0] refreshRow,
  output logic [15:0] cfgReg,
  output logic inDeepSleep,
  output logic selectViolation
);
  // pin bank: restore, select and supply each pass the same synchroniser
  localparam int PIN_RESTORE = 0;
  localparam int PIN_SELECT = 1;
  localparam int PIN_SUPPLY = 2;
  localparam int PIN_N = 3;

  // level each pin is taken to rest at while rst holds the bank; restore
  // reads as asserted and select as idle, so nothing starts before a sample
  localparam logic [PIN_N-1:0] PIN_IDLE = 3'h2;

  // default values put back by a restore or a power loss
  localparam logic [ROW_W-1:0] ROW_DEF = ROW_W'(`PRS_ROW_RST);
  localparam logic [15:0] CFG_DEF = `PRS_CFG_RST;

  // raw levels, gathered so one loop serves all of them
  wire logic [PIN_N-1:0] pinRaw;
  assign pinRaw[PIN_RESTORE] = link.restoreN;
  assign pinRaw[PIN_SELECT] = link.selectN;
  assign pinRaw[PIN_SUPPLY] = supplyOk;
  // settled levels after three flops and agreement of the last two
  wire logic [PIN_N-1:0] pinLvl;

  // three-stage synchronisers; stage 1 feeds only stage 2
  // a level is taken only when stages 2 and 3 agree, so a glitch that
  // slips past the first flop never reaches the sequence
  for (genvar p = 0; p < PIN_N; p++) begin : g_pinSync
    logic [2:0] sync_q;
    logic lvl_q;
    wire logic agree = (sync_q[1] == sync_q[2]);
    always_ff @(posedge clk) begin
      if (rst) begin
        sync_q <= {3{PIN_IDLE[p]}};
        lvl_q <= PIN_IDLE[p];
      end else begin
        sync_q <= {sync_q[1:0], pinRaw[p]};
        if (agree) lvl_q <= sync_q[2];
      end
    end
    assign pinLvl[p] = lvl_q;
  end

  // settled pin meanings
  wire logic restoreHi = pinLvl[PIN_RESTORE];
  wire logic restoreLo = ~pinLvl[PIN_RESTORE];
  wire logic selectLo = ~pinLvl[PIN_SELECT];
  wire logic powered = pinLvl[PIN_SUPPLY];

  // state and init counter
  // OFF: no supply; INIT: array walk; READY: normal use;
  // SLEEP: deepest sleep; HOLD: restore held low, refresh halted
  prs_dev_e state_q, state_d;
  logic [31:0] initCnt_q;
  // the pin bank adds a fixed lag before restore high is seen, so the count
  // is cut by that lag and ready still comes within the bound after the pin
  localparam int INIT_END = INIT_CYC - 1 - `PRS_PIN_LAT_CYC;
  wire logic initDone = (initCnt_q >= INIT_END);

  // decoded state and the conditions that steer the sequence
  wire logic inOff = (state_q == PRS_OFF);
  wire logic inInit = (state_q == PRS_INIT);
  wire logic inReady = (state_q == PRS_READY);
  wire logic inHold = (state_q == PRS_HOLD);
  wire logic startInit = powered && restoreHi;
  wire logic forceHold = powered && restoreLo && !inOff;

  // next state; a power loss, or a restore in any state but OFF, overrides whatever the case picks
  always_comb begin
    state_d = state_q;
    case (state_q)
      PRS_OFF: begin
        if (startInit) state_d = PRS_INIT;
      end
      PRS_INIT: begin
        if (initDone) state_d = PRS_READY;
      end
      PRS_READY: begin
        if (sleepReq) state_d = PRS_SLEEP;
      end
      PRS_SLEEP: begin
        // only a restore or a power loss leaves deepest sleep
        state_d = PRS_SLEEP;
      end
      default: begin
        // refresh was halted, so the array is walked again before use
        if (restoreHi) state_d = PRS_INIT;
      end
    endcase
    // restore low overrides any state but OFF, including deepest sleep
    if (forceHold) state_d = PRS_HOLD;
    if (!powered) state_d = PRS_OFF;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) state_q <= PRS_OFF;
    else state_q <= state_d;
  end

  // init counter runs only in INIT, so each entry starts from zero;
  // 32 bits leave room for any init time a slower clock might need
  wire logic [31:0] initCnt_d = inInit ? (initCnt_q + 32'h1) : 32'h0;
  always_ff @(posedge clk) begin
    if (rst) initCnt_q <= 32'h0;
    else initCnt_q <= initCnt_d;
  end

  // registers that a restore or a power loss puts back to defaults
  wire logic toDefault = rst || inOff || inHold;

  // refresh engine: steps one row per cycle while allowed; halted in hold
  // and in deepest sleep, so rows near the old position may miss a deadline
  wire logic refreshRun = inInit || inReady;
  wire logic [ROW_W-1:0] rowNext = refreshRow + ROW_W'(1); // wraps over the array
  always_ff @(posedge clk) begin
    if (toDefault) refreshRow <= ROW_DEF;
    else if (refreshRun) refreshRow <= rowNext;
  end

  // configuration register, defaults on restore or power loss; a write
  // outside ready is dropped rather than queued, which keeps this simple
  wire logic cfgTake = cfgWrEn && inReady;
  always_ff @(posedge clk) begin
    if (toDefault) cfgReg <= CFG_DEF;
    else if (cfgTake) cfgReg <= cfgWrData;
  end

  // select seen in INIT or HOLD is a protocol fault; sticky until power loss,
  // so the cause survives the restore that the host issues to recover
  wire logic badSelect = selectLo && (inInit || inHold);
  wire logic violClear = rst || inOff;
  always_ff @(posedge clk) begin
    if (violClear) selectViolation <= 1'b0;
    else if (badSelect) selectViolation <= 1'b1;
  end

  // status decoded from the next state, so each flag moves with the state
  wire logic readyNext = (state_d == PRS_READY);
  wire logic sleepNext = (state_d == PRS_SLEEP);

  // ready flag
  always_ff @(posedge clk) begin
    if (rst) ready <= 1'b0;
    else ready <= readyNext;
  end

  // refresh status follows the engine one cycle later
  always_ff @(posedge clk) begin
    if (rst) refreshOn <= 1'b0;
    else refreshOn <= refreshRun;
  end

  // deepest sleep status
  always_ff @(posedge clk) begin
    if (rst) inDeepSleep <= 1'b0;
    else inDeepSleep <= sleepNext;
  end
endmodule // prs_device
`default_nettype wire

// ---- rtl/prs_host.sv ----
// prs_host.sv: host end; drives restore and select with the required gaps.
// assumes the device end on the same clk through prs_link_if.
`timescale 1ns/100ps
`default_nettype none
`include "prs_cfg.svh"
module prs_host
  import prs_pkg::*;
#(
  parameter int INIT_CYC = `PRS_INIT_CYC,
  parameter int RP_CYC = `PRS_RP_CYC,
  parameter int RH_CYC = `PRS_RH_CYC,
  parameter int RPH_CYC = `PRS_RPH_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  prs_link_if.host link,
  // user side
  input wire logic restoreReq,
  input wire logic accessReq,
  input wire logic accessEnd,
  output logic accessAllowed,
  output logic dataLost
);
  prs_host_e state_q, state_d;
  logic [31:0] cnt_q;
  logic [31:0] sinceFall_q;
  wire logic pulseDone = (cnt_q >= RP_CYC - 1);
  // select waits for both gaps: after rise and after the fall
  wire logic gapDone = (cnt_q >= RH_CYC - 1) && (sinceFall_q >= RPH_CYC - 1);
  // init time counted from restore high covers power-up too
  wire logic initDone = (cnt_q >= INIT_CYC - 1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      PRH_RESET: begin
        if (pulseDone) state_d = PRH_GAP;
      end
      PRH_GAP: begin
        if (gapDone && initDone) state_d = PRH_IDLE;
      end
      PRH_IDLE: begin
        if (accessReq) state_d = PRH_BUSY;
      end
      default: begin
        if (accessEnd) state_d = PRH_IDLE;
      end
    endcase
    if (restoreReq && state_q != PRH_RESET) state_d = PRH_RESET;
  end
  always_ff @(posedge clk) begin
    if (rst) state_q <= PRH_RESET;
    else state_q <= state_d;
  end
  // cnt restarts on each state change into RESET or GAP
  always_ff @(posedge clk) begin
    if (rst || (state_d != state_q)) cnt_q <= 32'h0;
    else if (state_q == PRH_RESET || state_q == PRH_GAP) cnt_q <= cnt_q + 32'h1;
  end
  always_ff @(posedge clk) begin
    if (rst || (state_d == PRH_RESET && state_q != PRH_RESET)) sinceFall_q <= 32'h0;
    else if (sinceFall_q != 32'hffffffff) sinceFall_q <= sinceFall_q + 32'h1;
  end
  // pins from flops; select high until idle gap done
  always_ff @(posedge clk) begin
    if (rst) begin
      link.restoreN <= 1'b0;
      link.selectN <= 1'b1;
      dataLost <= 1'b1;
    end else begin
      link.restoreN <= (state_d != PRH_RESET);
      link.selectN <= (state_d != PRH_BUSY);
      if (state_d == PRH_RESET) dataLost <= 1'b1;
      else if (state_d == PRH_BUSY) dataLost <= 1'b0;
    end
  end
  assign accessAllowed = (state_q == PRH_IDLE);
endmodule // prs_host
`default_nettype wire

// ---- verification/prs_link_props.sv ----
// prs_link_props.sv: timing checks on the restore and select link.
// assumes host and device share clk and rst; counts are in cycles.
`timescale 1ns/100ps
`default_nettype none
module prs_link_props #(
  parameter int INIT_CYC = 50,
  parameter int RP_CYC = 40,
  parameter int RH_CYC = 40,
  parameter int RPH_CYC = 80
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link and device status
  input wire logic restoreN,
  input wire logic selectN,
  input wire logic ready,
  input wire logic refreshOn
);
  localparam int ILO = INIT_CYC;
  localparam int IHI = INIT_CYC + 8;
  logic [15:0] lowCnt_q, highCnt_q, fallCnt_q;
  logic restoreN_q;
  // cycles low, high and since fall; high and since-fall counts saturate so long idle never wraps
  always_ff @(posedge clk) begin
    restoreN_q <= restoreN;
    lowCnt_q <= (rst || restoreN) ? 16'h0 : lowCnt_q + 16'h1;
    highCnt_q <= (rst || !restoreN) ? 16'h0 : highCnt_q + {15'h0, ~&highCnt_q};
    fallCnt_q <= (rst || (restoreN_q && !restoreN)) ? 16'h0 : fallCnt_q + {15'h0, ~&fallCnt_q};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  pulse_min_a: assert property ($rose(restoreN) |-> lowCnt_q >= RP_CYC)
    else $error("restore pulse too short");
  sel_hold_a: assert property (!restoreN |-> selectN)
    else $error("select low during restore");
  rise_gap_a: assert property ($fell(selectN) |-> highCnt_q >= RH_CYC)
    else $error("select too soon after restore rise");
  fall_gap_a: assert property ($fell(selectN) |-> fallCnt_q >= RPH_CYC)
    else $error("select too soon after restore fall");
  init_quiet_a: assert property ($fell(selectN) |-> highCnt_q >= INIT_CYC)
    else $error("select during init");
  ready_time_a: assert property ($rose(restoreN) |-> !ready ##[ILO:IHI] ready)
    else $error("ready not on time");
  ready_drop_a: assert property (!restoreN [*8] |-> !ready)
    else $error("ready during restore");
  refresh_halt_a: assert property (!restoreN [*8] |-> !refreshOn)
    else $error("refresh during restore");
  refresh_back_a: assert property ($rose(restoreN) |-> ##[1:8] refreshOn)
    else $error("refresh not resumed");
endmodule // prs_link_props
`default_nettype wire

// ---- verification/testbench.sv ----
// testbench.sv: host and device joined by the link, random and corner stimulus.
// assumes a short init count on both ends; the checker watches the link.
`timescale 1ns/100ps
`default_nettype none
`include "prs_cfg.svh"
module testbench;
  localparam int INIT = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic supplyOk = 1'b1;
  logic sleepReq = 1'b0;
  logic cfgWrEn = 1'b0;
  logic restoreReq = 1'b0;
  logic accessReq = 1'b0;
  logic accessEnd = 1'b0;
  logic [15:0] cfgWrData = 16'h0;
  logic [15:0] cfgReg, refreshRow, data;
  logic ready, refreshOn, inDeepSleep, selectViolation, accessAllowed, dataLost;
  int err_count = 0;
  int total_checks = 0;
  prs_link_if prs_link_if_inst ();
  prs_device #(.INIT_CYC(INIT)) prs_device_inst (.clk(clk), .rst(rst), .supplyOk(supplyOk),
    .link(prs_link_if_inst.dev), .sleepReq(sleepReq), .cfgWrData(cfgWrData),
    .cfgWrEn(cfgWrEn), .ready(ready), .refreshOn(refreshOn), .refreshRow(refreshRow),
    .cfgReg(cfgReg), .inDeepSleep(inDeepSleep), .selectViolation(selectViolation));
  prs_host #(.INIT_CYC(INIT)) prs_host_inst (.clk(clk), .rst(rst),
    .link(prs_link_if_inst.host), .restoreReq(restoreReq), .accessReq(accessReq),
    .accessEnd(accessEnd), .accessAllowed(accessAllowed), .dataLost(dataLost));
  prs_link_props #(.INIT_CYC(INIT), .RP_CYC(`PRS_RP_CYC), .RH_CYC(`PRS_RH_CYC),
    .RPH_CYC(`PRS_RPH_CYC)) prs_link_props_inst (.clk(clk), .rst(rst),
    .restoreN(prs_link_if_inst.restoreN), .selectN(prs_link_if_inst.selectN),
    .ready(ready), .refreshOn(refreshOn));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // inputs move 1 ns after the edge so sampling never races
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  // a restore always wins over the last written value
  function automatic logic [15:0] cfgExp(input logic restored, input logic [15:0] wr);
    return restored ? `PRS_CFG_RST : wr;
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // bounded wait for both ends to finish init
  task automatic waitRdy();
    for (int i = 0; i < 300 && !(ready === 1'b1 && accessAllowed === 1'b1); i++) tick(1);
    chkb(ready & accessAllowed, 1'b1);
  endtask
  task automatic doRestore();
    restoreReq = 1'b1;
    tick(1);
    restoreReq = 1'b0;
    tick(10);
    chkb(ready, 1'b0);
    chk(refreshRow, `PRS_ROW_RST);
    chk(cfgReg, cfgExp(1'b1, data));
    chkb(inDeepSleep, 1'b0);
    chkb(dataLost, 1'b1);
    waitRdy();
  endtask
  task automatic doAccess();
    accessReq = 1'b1;
    tick(1);
    accessReq = 1'b0;
    tick(1);
    chkb(prs_link_if_inst.selectN, 1'b0);
    chkb(dataLost, 1'b0);
    chkb(selectViolation, 1'b0);
    accessEnd = 1'b1;
    tick(1);
    accessEnd = 1'b0;
    tick(2);
    chkb(prs_link_if_inst.selectN, 1'b1);
  endtask
  initial begin
    data = 16'($urandom(32'h4fa3a6f8));
    tick(16);
    rst = 1'b0;
    tick(20);
    chkb(ready, 1'b0);
    chkb(accessAllowed, 1'b0);
    waitRdy();
    for (int i = 0; i < 6; i++) begin
      data = 16'($urandom());
      cfgWrData = data;
      cfgWrEn = 1'b1;
      tick(1);
      cfgWrEn = 1'b0;
      tick(2);
      chk(cfgReg, cfgExp(1'b0, data));
      doAccess();
      // first pass restores after the write and its access, later ones at random
      if (data[0] || i == 0) doRestore();
    end
    sleepReq = 1'b1;
    tick(5);
    chkb(inDeepSleep, 1'b1);
    sleepReq = 1'b0;
    doRestore();
    doAccess();
    // shallow supply dip: device state is lost, so the host must restore
    supplyOk = 1'b0;
    tick(8);
    chkb(ready, 1'b0);
    chk(cfgReg, cfgExp(1'b1, data));
    supplyOk = 1'b1;
    doRestore();
    doAccess();
    end_sim();
  end
  // watchdog, far beyond the thousand or so cycles the run needs
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
